// >>> logic/cpu_core_register_set.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_core_register_set
  import core_regs_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic op_valid,
  input wire op_type op_code,
  input wire logic [7:0] operand,
  input wire logic [15:0] ip_load,
  input wire logic [7:0] read_data,
  input wire logic cfg_write,
  input wire logic [15:0] cfg_addr,
  input wire logic [7:0] cfg_data,
  output logic [7:0] acc,
  output logic [7:0] index_x,
  output logic [7:0] index_y,
  output logic [7:0] stack_pointer,
  output logic [7:0] cpu_flags_byte,
  output logic [15:0] instruction_pointer,
  output logic [7:0] cpu_config_reg,
  output logic [15:0] ea_x,
  output logic [15:0] ea_y,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic mem_write,
  output logic mem_read,
  output logic halted,
  output logic paused,
  output logic illegal_op
);

  stack_port_if sp();

  stack_unit u_stack (
    .clock(clock),
    .nrst(nrst),
    .sp(sp.owner)
  );

  logic [7:0] instruction_pointer_high;
  logic [7:0] instruction_pointer_low;
  logic [7:0] next_acc, next_x, next_y, next_flags, next_cfg;
  logic [7:0] next_iph, next_ipl;
  logic [15:0] next_ea_x, next_ea_y, next_mem_addr;
  logic [7:0] next_wdata, next_sp;
  logic next_write, next_read, next_halt, next_pause, next_illegal;
  logic [15:0] product;
  phase_type phase, next_phase;
  op_type pending_pop, next_pending;

  function automatic logic [15:0] index_sum(input logic [7:0] a,
                                            input logic [7:0] b);
    index_sum = {8'h00, a} + {8'h00, b};
  endfunction

  assign product = {8'h00, acc} * {8'h00, index_y};

  // ==========================================================
  // Next-state computation
  always_comb begin
    next_acc = acc;
    next_x = index_x;
    next_y = index_y;
    next_flags = cpu_flags_byte;
    next_cfg = cpu_config_reg;
    next_iph = instruction_pointer_high;
    next_ipl = instruction_pointer_low;
    next_ea_x = index_sum(operand, index_x);
    next_ea_y = index_sum(operand, index_y);
    next_mem_addr = EA_NONE;
    next_wdata = MEM_NONE;
    next_write = 1'b0;
    next_read = 1'b0;
    next_halt = halted;
    next_pause = paused;
    next_illegal = 1'b0;
    next_phase = st_idle;
    next_sp = sp.pointer;
    sp.push = 1'b0;
    sp.pop = 1'b0;
    sp.page = cpu_config_reg[STACK_PAGE_BIT];
    if (cfg_write && cfg_addr == CPU_CONFIG_ADDR) begin
      next_cfg = cfg_data;
    end
    // Halt and pause block the operations, but config writes still land; only reset wakes the core.
    if (op_valid && !halted && !paused) begin
      case (op_code)
        op_load_acc: next_acc = operand;
        op_load_x: next_x = operand;
        op_load_y: next_y = operand;
        op_load_ip: {next_iph, next_ipl} = ip_load;
        op_step_ip: {next_iph, next_ipl} = instruction_pointer + 16'h0001;
        acc_push_op, flags_push_op: begin
          sp.push = 1'b1;
          next_sp = sp.pointer - 8'h01;
          next_write = 1'b1;
          next_mem_addr = sp.address;
          next_wdata = (op_code == acc_push_op) ? acc : cpu_flags_byte;
          next_phase = st_write;
        end
        acc_pop_op, flags_pop_op: begin
          sp.pop = 1'b1;
          next_sp = sp.pointer + 8'h01;
          next_read = 1'b1;
          next_mem_addr = sp.address;
          next_phase = st_read;
        end
        oscillator_halt_op: next_halt = 1'b1;
        clock_pause_op: next_pause = 1'b1;
        product_op: {next_y, next_acc} = product;
        quotient_op: begin
          // A zero divisor leaves both registers untouched.
          if (index_x != 8'h00) begin
            next_acc = acc / index_x;
            next_x = acc % index_x;
          end
        end
        unsupported_op_one, unsupported_op_two: next_illegal = 1'b1;
        default: next_illegal = 1'b0;
      endcase
    end
    // Popped data lands one edge after the read strobe.
    if (phase == st_read) begin
      next_phase = st_idle;
      if (pending_pop == acc_pop_op) begin
        next_acc = read_data;
      end else begin
        next_flags = read_data;
      end
    end
  end

  // Popped data arrives one cycle after the read strobe.
  always_comb begin
    next_pending = pending_pop;
    if (sp.pop) begin
      next_pending = op_code;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      acc <= ACC_RESET;
      index_x <= INDEX_RESET;
      index_y <= INDEX_RESET;
      cpu_flags_byte <= FLAGS_RESET;
      cpu_config_reg <= CONFIG_RESET;
      instruction_pointer_high <= IP_RESET[15:8];
      instruction_pointer_low <= IP_RESET[7:0];
      ea_x <= EA_NONE;
      ea_y <= EA_NONE;
      mem_addr <= EA_NONE;
      mem_wdata <= MEM_NONE;
      mem_write <= 1'b0;
      mem_read <= 1'b0;
      halted <= 1'b0;
      paused <= 1'b0;
      illegal_op <= 1'b0;
      phase <= st_idle;
      pending_pop <= op_none;
      stack_pointer <= STACK_RESET;
      instruction_pointer <= IP_RESET;
    end else begin
      acc <= next_acc;
      index_x <= next_x;
      index_y <= next_y;
      cpu_flags_byte <= next_flags;
      cpu_config_reg <= next_cfg;
      instruction_pointer_high <= next_iph;
      instruction_pointer_low <= next_ipl;
      ea_x <= next_ea_x;
      ea_y <= next_ea_y;
      mem_addr <= next_mem_addr;
      mem_wdata <= next_wdata;
      mem_write <= next_write;
      mem_read <= next_read;
      halted <= next_halt;
      paused <= next_pause;
      illegal_op <= next_illegal;
      phase <= next_phase;
      pending_pop <= next_pending;
      stack_pointer <= next_sp;
      instruction_pointer <= {next_iph, next_ipl};
    end
  end

  // ==========================================================
  // Checks
  property p_ea_x;
    @(posedge clock) disable iff (!nrst)
      1'b1 |=> ea_x == {8'h00, $past(operand)} + {8'h00, $past(index_x)};
  endproperty
  a_ea_x: assert property (p_ea_x)
    else $error("Indexed address from first index is wrong.");

  property p_ea_y;
    @(posedge clock) disable iff (!nrst)
      1'b1 |=> ea_y == {8'h00, $past(operand)} + {8'h00, $past(index_y)};
  endproperty
  a_ea_y: assert property (p_ea_y)
    else $error("Indexed address from second index is wrong.");

  property p_load_acc;
    @(posedge clock) disable iff (!nrst)
      op_valid && op_code == op_load_acc && !halted && !paused
      |=> acc == $past(operand);
  endproperty
  a_load_acc: assert property (p_load_acc)
    else $error("Accumulator did not take the operand.");

  property p_push_addr;
    @(posedge clock) disable iff (!nrst)
      mem_write |-> mem_addr[7:0] == stack_pointer + 8'h01;
  endproperty
  a_push_addr: assert property (p_push_addr)
    else $error("Push address is not the old stack pointer.");

  property p_pop_addr;
    @(posedge clock) disable iff (!nrst)
      mem_read |-> mem_addr[7:0] == stack_pointer;
  endproperty
  a_pop_addr: assert property (p_pop_addr)
    else $error("Pop address is not the raised stack pointer.");

  property p_page_hi;
    @(posedge clock) disable iff (!nrst)
      (mem_read || mem_write)
      |-> mem_addr[15:8] == {7'h00, $past(cpu_config_reg[STACK_PAGE_BIT])};
  endproperty
  a_page_hi: assert property (p_page_hi)
    else $error("Stack page byte wrong.");

  property p_illegal;
    @(posedge clock) disable iff (!nrst)
      illegal_op |-> $stable(acc) && $stable(index_x);
  endproperty
  a_illegal: assert property (p_illegal)
    else $error("Unsupported operation changed a register.");

  property p_step_ip;
    @(posedge clock) disable iff (!nrst)
      op_valid && op_code == op_step_ip && !halted && !paused
      |=> instruction_pointer == $past(instruction_pointer) + 16'h0001;
  endproperty
  a_step_ip: assert property (p_step_ip)
    else $error("Instruction pointer did not step.");

  property p_halt;
    @(posedge clock) disable iff (!nrst)
      op_valid && op_code == oscillator_halt_op && !paused
      |=> halted ##1 halted;
  endproperty
  a_halt: assert property (p_halt)
    else $error("Halt operation did not stop the core.");

  property p_cfg;
    @(posedge clock) disable iff (!nrst)
      cfg_write && cfg_addr == CPU_CONFIG_ADDR
      |=> cpu_config_reg == $past(cfg_data);
  endproperty
  a_cfg: assert property (p_cfg)
    else $error("Configuration register write lost.");

endmodule
`default_nettype wire

// >>> logic/core_regs_pkg.sv
package core_regs_pkg;

  // ==========================================================
  // Register widths and reset values
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 16;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] INDEX_RESET = 8'h00;
  localparam logic [7:0] STACK_RESET = 8'hFF;
  localparam logic [7:0] FLAGS_RESET = 8'h04;
  localparam logic [15:0] IP_RESET = 16'h0000;
  localparam logic [7:0] CONFIG_RESET = 8'h00;

  // ==========================================================
  // Configuration register address and field position
  localparam logic [15:0] CPU_CONFIG_ADDR = 16'h003B;
  localparam int STACK_PAGE_BIT = 2;
  localparam logic [7:0] STACK_PAGE_LOW = 8'h00;
  localparam logic [7:0] STACK_PAGE_HIGH = 8'h01;

  // ==========================================================
  // Operations offered by the core to its sequencer
  typedef enum logic [3:0] {
    op_none = 4'h0,
    op_load_acc = 4'h1,
    op_load_x = 4'h2,
    op_load_y = 4'h3,
    op_load_ip = 4'h4,
    op_step_ip = 4'h5,
    acc_push_op = 4'h6,
    acc_pop_op = 4'h7,
    flags_push_op = 4'h8,
    flags_pop_op = 4'h9,
    oscillator_halt_op = 4'hA,
    clock_pause_op = 4'hB,
    product_op = 4'hC,
    quotient_op = 4'hD,
    unsupported_op_one = 4'hE,
    unsupported_op_two = 4'hF
  } op_type;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_write = 2'b01,
    st_read = 2'b11,
    st_stall = 2'b10
  } phase_type;

  localparam logic [7:0] MEM_NONE = 8'h00;
  localparam logic [15:0] EA_NONE = 16'h0000;

endpackage

// >>> logic/stack_port_if.sv
`timescale 1ns/1ps
`default_nettype none
interface stack_port_if;
  logic push;
  logic pop;
  logic page;
  logic [7:0] pointer;
  logic [15:0] address;
  modport owner(output push, output pop, output page, input pointer,
                input address);
  modport unit(input push, input pop, input page, output pointer,
               output address);
endinterface
`default_nettype wire

// >>> logic/stack_unit.sv
`timescale 1ns/1ps
`default_nettype none
module stack_unit
  import core_regs_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  stack_port_if.unit sp
);

  logic [7:0] pointer;
  logic [7:0] next_pointer;

  // ==========================================================
  // Write-then-decrement on push, increment-then-read on pop.
  always_comb begin
    next_pointer = pointer;
    if (sp.push) begin
      next_pointer = pointer - 8'h01;
    end else if (sp.pop) begin
      next_pointer = pointer + 8'h01;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pointer <= STACK_RESET;
    end else begin
      pointer <= next_pointer;
    end
  end

  // A pop must address the slot above the pointer, so it uses next.
  always_comb begin
    sp.pointer = pointer;
    sp.address = {(sp.page ? STACK_PAGE_HIGH : STACK_PAGE_LOW),
                  (sp.pop ? next_pointer : pointer)};
  end

  property p_push_dec;
    @(posedge clock) disable iff (!nrst)
      sp.push |=> pointer == $past(pointer) - 8'h01;
  endproperty
  a_push_dec: assert property (p_push_dec)
    else $error("Stack pointer did not drop after push.");

  property p_page;
    @(posedge clock) disable iff (!nrst)
      sp.address[15:8] == (sp.page ? 8'h01 : 8'h00);
  endproperty
  a_page: assert property (p_page)
    else $error("Stack high byte does not follow page bit.");

endmodule
`default_nettype wire

// >>> test/cpu_core_register_set_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_core_register_set_tb
  import core_regs_pkg::*;
;
  // ==========================================================
  // Stimulus, design and bookkeeping
  typedef struct {
    op_type op;
    logic [7:0] opnd;
    logic [7:0] acc;
    logic [7:0] x;
    logic [7:0] y;
    logic ill;
  } row_type;
  logic clock, nrst, op_valid, cfg_write;
  op_type op_code;
  logic [7:0] operand, read_data, cfg_data;
  logic [15:0] ip_load, cfg_addr;
  logic [7:0] acc, index_x, index_y, stack_pointer, cpu_flags_byte;
  logic [7:0] cpu_config_reg, mem_wdata;
  logic [15:0] instruction_pointer, ea_x, ea_y, mem_addr;
  logic mem_write, mem_read, halted, paused, illegal_op;
  int fail_count = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [7:0] exp_sp;
  row_type rows [9];

  cpu_core_register_set i_cpu_core_register_set (
    .clock(clock), .nrst(nrst), .op_valid(op_valid), .op_code(op_code),
    .operand(operand), .ip_load(ip_load), .read_data(read_data),
    .cfg_write(cfg_write), .cfg_addr(cfg_addr), .cfg_data(cfg_data),
    .acc(acc), .index_x(index_x), .index_y(index_y),
    .stack_pointer(stack_pointer), .cpu_flags_byte(cpu_flags_byte),
    .instruction_pointer(instruction_pointer),
    .cpu_config_reg(cpu_config_reg), .ea_x(ea_x), .ea_y(ea_y),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_write(mem_write),
    .mem_read(mem_read), .halted(halted), .paused(paused),
    .illegal_op(illegal_op)
  );

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // A hang would otherwise stall the run with no verdict.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      fail_count++;
      test_done();
    end
  end

  // ==========================================================
  // Tasks
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check8(input logic [7:0] got, input logic [7:0] exp,
                        input string what);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s %h not %h", $time, what, got, exp);
    end
  endtask

  task automatic check16(input logic [15:0] got, input logic [15:0] exp,
                         input string what);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s %h not %h", $time, what, got, exp);
    end
  endtask

  task automatic check1(input logic got, input logic exp, input string what);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s %b not %b", $time, what, got, exp);
    end
  endtask

  task automatic do_reset();
    nrst <= 1'b0;
    repeat (20) @(posedge clock);
    check8(acc, ACC_RESET, "acc reset");
    check8(stack_pointer, STACK_RESET, "sp reset");
    check16(instruction_pointer, IP_RESET, "ip reset");
    check8(cpu_config_reg, CONFIG_RESET, "config reset");
    check1(halted, 1'b0, "halt reset");
    check1(paused, 1'b0, "pause reset");
    nrst <= 1'b1;
    exp_sp = STACK_RESET;
  endtask

  // The op is taken at the second edge; results are looked at just after.
  task automatic do_op(input op_type op, input logic [7:0] opnd,
                       input logic [7:0] rd);
    @(posedge clock);
    op_valid <= 1'b1;
    op_code <= op;
    operand <= opnd;
    read_data <= rd;
    @(posedge clock);
    op_valid <= 1'b0;
    #1;
  endtask

  task automatic write_cfg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    cfg_write <= 1'b1;
    cfg_addr <= a;
    cfg_data <= d;
    @(posedge clock);
    cfg_write <= 1'b0;
    #1;
  endtask

  // Read data is held through the pop cycle, so it is sampled in time.
  task automatic stack_op(input op_type op, input logic [7:0] page,
                          input logic [7:0] data, input logic push);
    do_op(op, 8'h00, data);
    if (push) begin
      check1(mem_write, 1'b1, "write strobe");
      check16(mem_addr, {page, exp_sp}, "push addr");
      check8(mem_wdata, data, "push data");
      exp_sp = exp_sp - 8'h01;
    end else begin
      exp_sp = exp_sp + 8'h01;
      check1(mem_read, 1'b1, "read strobe");
      check16(mem_addr, {page, exp_sp}, "pop addr");
      @(posedge clock);
      #1;
      check1(mem_read, 1'b0, "read drop");
    end
    check8(stack_pointer, exp_sp, "sp");
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    nrst = 1'b0;
    op_valid = 1'b0;
    op_code = op_none;
    operand = 8'h00;
    read_data = 8'h00;
    ip_load = 16'h0000;
    cfg_write = 1'b0;
    cfg_addr = 16'h0000;
    cfg_data = 8'h00;
    rows[0] = '{op_load_acc, 8'h9C, 8'h9C, 8'h00, 8'h00, 1'b0};
    rows[1] = '{op_load_x, 8'h05, 8'h9C, 8'h05, 8'h00, 1'b0};
    rows[2] = '{op_load_y, 8'h0C, 8'h9C, 8'h05, 8'h0C, 1'b0};
    rows[3] = '{product_op, 8'h00, 8'h50, 8'h05, 8'h07, 1'b0};
    rows[4] = '{quotient_op, 8'h00, 8'h10, 8'h00, 8'h07, 1'b0};
    rows[5] = '{quotient_op, 8'h00, 8'h10, 8'h00, 8'h07, 1'b0};
    rows[6] = '{unsupported_op_one, 8'h00, 8'h10, 8'h00, 8'h07, 1'b1};
    rows[7] = '{unsupported_op_two, 8'h00, 8'h10, 8'h00, 8'h07, 1'b1};
    rows[8] = '{op_load_x, 8'hFF, 8'h10, 8'hFF, 8'h07, 1'b0};
    do_reset();
    foreach (rows[i]) begin
      do_op(rows[i].op, rows[i].opnd, 8'h00);
      check8(acc, rows[i].acc, "acc");
      check8(index_x, rows[i].x, "x");
      check8(index_y, rows[i].y, "y");
      check1(illegal_op, rows[i].ill, "illegal");
    end
    operand <= 8'h80;
    repeat (2) @(posedge clock);
    #1;
    check16(ea_x, 16'h017F, "ea x");
    check16(ea_y, 16'h0087, "ea y");
    ip_load <= 16'hABCD;
    do_op(op_load_ip, 8'h00, 8'h00);
    check16(instruction_pointer, 16'hABCD, "ip");
    do_op(op_step_ip, 8'h00, 8'h00);
    check16(instruction_pointer, 16'hABCE, "ip step");
    stack_op(acc_push_op, STACK_PAGE_LOW, 8'h10, 1'b1);
    write_cfg(16'h003A, 8'h04);
    check8(cpu_config_reg, 8'h00, "config miss");
    write_cfg(CPU_CONFIG_ADDR, 8'h04);
    check8(cpu_config_reg, 8'h04, "config hit");
    stack_op(flags_push_op, STACK_PAGE_HIGH, FLAGS_RESET, 1'b1);
    stack_op(flags_pop_op, STACK_PAGE_HIGH, 8'hC9, 1'b0);
    check8(cpu_flags_byte, 8'hC9, "flags pop");
    stack_op(acc_pop_op, STACK_PAGE_HIGH, 8'h5A, 1'b0);
    check8(acc, 8'h5A, "acc pop");
    for (int i = 0; i < 2; i++) begin
      do_op(i == 0 ? oscillator_halt_op : clock_pause_op, 8'h00, 8'h00);
      check1(i == 0 ? halted : paused, 1'b1, "stopped");
      do_op(op_load_acc, 8'h33, 8'h00);
      check8(acc, i == 0 ? 8'h5A : ACC_RESET, "refused");
      do_reset();
    end
    test_done();
  end
endmodule
`default_nettype wire
